// *** design/awsf_top.sv ***
// alu with accumulator and flag register behind an avalon slave
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
module awsf_top
   import awsf_pkg::*;
(
   input  wire logic                   clock_i,
   input  wire logic                   rst_b_i,
   input  wire awsf_pkg::awsf_av_req_t av_i,
   output logic [31:0]                 av_readdata_o,
   output logic                        av_waitrequest_o,
   input  wire logic                   watchdog_timeout_i,
   input  wire logic                   low_voltage_reset_i,
   output logic [7:0]                  acc_o,
   output logic [7:0]                  flags_o
);
   import awsf_pkg::*;

   // module state apart from the flag register
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  opnd;
      logic [15:0] cmd;
      logic [7:0]  res;
      logic [7:0]  rdata;
      logic        ack;
   } awsf_top_st_t;

   awsf_top_st_t   q;
   awsf_top_st_t   d;
   awsf_alu_out_t  alu;
   awsf_flag_ctl_t fctl;
   awsf_op_t       op;
   logic           req;
   logic           take;
   logic           wr_go;
   logic           exec;
   logic           to_file;
   logic           to_flags;
   logic [7:0]     imm;
   logic [7:0]     file_val;
   logic [7:0]     a_op;
   logic [7:0]     b_op;
   logic [31:0]    wd;

   // request decode; one wait cycle, then the request is taken
   assign wd               = av_i.writedata;
   assign req              = av_i.read | av_i.write;
   assign take             = req & q.ack;
   assign wr_go            = take & av_i.write;
   assign av_waitrequest_o = req & ~q.ack;

   // command fields come straight from the write data
   assign op       = awsf_op_t'(wd[CMD_OP_LSB +: 4]);
   assign imm      = wd[CMD_IMM_LSB +: 8];
   assign exec     = wr_go && (av_i.address == CMD_OFS);
   assign to_flags = wd[CMD_DEST_FLAGS];
   assign to_file  = wd[CMD_DEST_FILE] | to_flags | (op == OP_BSET) |
                     (op == OP_BCLR) | (op == OP_ACC2F);

   // operand routing; flag register is the file when targeted
   always_comb begin
      file_val = to_flags ? flags_o : q.opnd;
      a_op     = q.acc;
      b_op     = wd[CMD_USE_IMM] ? imm : file_val;
      if (wd[CMD_SRC_ACC]) begin
         b_op = q.acc;
      end
   end

   awsf_alu_core awsf_alu_core_inst (
      .op_i  (op),
      .a_i   (a_op),
      .b_i   (b_op),
      .cin_i (flags_o[FLG_C]),
      .bit_i (imm[2:0]),
      .out_o (alu)
   );

   // flag register control for this cycle
   always_comb begin
      fctl         = '0;
      fctl.wdt_to  = watchdog_timeout_i;
      fctl.lv_rst  = low_voltage_reset_i;
      fctl.alu     = alu.flg;
      if (wr_go && (av_i.address == FLAGS_OFS)) begin
         fctl.wr    = 1'b1;
         fctl.wdata = wd[2:0];
      end
      if (exec) begin
         fctl.upd     = alu.upd;
         fctl.wdt_clr = (op == OP_WDTCLR);
         fctl.sleep   = (op == OP_SLEEP);
         if (to_flags && (op != OP_WDTCLR) && (op != OP_SLEEP)) begin
            fctl.wr    = 1'b1;
            fctl.wdata = alu.res[2:0];
         end
      end
   end

   awsf_flag_reg awsf_flag_reg_inst (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .ctl_i   (fctl),
      .flags_o (flags_o)
   );

   // next state: bus writes, command execution and read capture
   always_comb begin
      d     = q;
      d.ack = req & ~q.ack;
      if (wr_go) begin
         unique case (av_i.address)
            ACC_OFS:  d.acc  = wd[7:0];
            OPND_OFS: d.opnd = wd[7:0];
            CMD_OFS:  d.cmd  = wd[15:0];
            default:  d.acc  = q.acc;
         endcase
      end
      if (exec && (op != OP_WDTCLR) && (op != OP_SLEEP)) begin
         d.res = alu.res;
         if (!to_file) begin
            d.acc = alu.res;
         end
      end
      if (av_i.read && !q.ack) begin
         unique case (av_i.address)
            ACC_OFS:   d.rdata = q.acc;
            OPND_OFS:  d.rdata = q.opnd;
            CMD_OFS:   d.rdata = q.cmd[7:0];
            RES_OFS:   d.rdata = q.res;
            FLAGS_OFS: d.rdata = flags_o;
            default:   d.rdata = DATA_RST;
         endcase
      end
   end

   // state register
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         q.acc   <= DATA_RST;
         q.opnd  <= DATA_RST;
         q.cmd   <= CMD_RST;
         q.res   <= DATA_RST;
         q.rdata <= DATA_RST;
         q.ack   <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // outputs from flip-flops
   assign av_readdata_o = {24'h000000, q.rdata};
   assign acc_o         = q.acc;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   // bus handshake: exactly one wait cycle per request
   one_wait_a: assert property (req && !q.ack |=> req |-> !av_waitrequest_o)
      else $error("request not answered after one wait cycle");

   add_result_a: assert property (exec && op == OP_ADD && !to_file &&
      !low_voltage_reset_i |=> {flags_o[FLG_C], acc_o} ==
      ($past({1'b0, a_op}) + $past({1'b0, b_op})))
      else $error("add result or carry wrong");

   sub_nibble_a: assert property (exec && op == OP_SUB && !to_flags &&
      !low_voltage_reset_i |=> flags_o[FLG_NIB] ==
      ($past(b_op[3:0]) >= $past(a_op[3:0])))
      else $error("subtract nibble not-borrow wrong");

   sub_borrow_a: assert property (exec && op == OP_SUB && !to_flags &&
      !low_voltage_reset_i |=> flags_o[FLG_C] == ($past(b_op) >= $past(a_op)))
      else $error("subtract carry is not inverted borrow");

   zero_flag_a: assert property (exec && alu.upd[FLG_Z] &&
      !low_voltage_reset_i |=> flags_o[FLG_Z] == ($past(alu.res) == 8'h00))
      else $error("zero flag does not follow result");

   imm_operand_a: assert property (exec && op == OP_MOV && wd[CMD_USE_IMM] &&
      !wd[CMD_SRC_ACC] && !to_file |=> acc_o == $past(imm))
      else $error("immediate operand not used");

   acc_single_a: assert property (exec && op == OP_COM && wd[CMD_SRC_ACC] &&
      !to_file |=> acc_o == ~$past(acc_o))
      else $error("single operand did not take accumulator");

   flag_bitset_a: assert property (exec && op == OP_BSET && to_flags &&
      imm[2:0] < 3'h3 && !low_voltage_reset_i |=>
      flags_o[$past(imm[1:0])] && $stable(acc_o))
      else $error("bit set on flags not written");

   sw_no_sleep_a: assert property (wr_go && av_i.address == FLAGS_OFS &&
      !watchdog_timeout_i && !low_voltage_reset_i |=> $stable(flags_o[FLG_SLP]))
      else $error("software write changed sleep flag");

   // software write cannot move the watchdog flag
   sw_no_wdog_a: assert property (wr_go && av_i.address == FLAGS_OFS &&
      !watchdog_timeout_i && !low_voltage_reset_i |=> $stable(flags_o[FLG_WDOG]))
      else $error("software write changed watchdog flag");

   // software write lands in the arithmetic flags
   sw_flag_write_a: assert property (wr_go && av_i.address == FLAGS_OFS &&
      !low_voltage_reset_i |=> flags_o[2:0] == $past(wd[2:0]))
      else $error("software flag write lost");

   // upper read data bits stay zero
   rdata_upper_a: assert property (av_readdata_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");

   // accumulator written from the bus
   acc_write_a: assert property (wr_go && av_i.address == ACC_OFS |=>
      acc_o == $past(wd[7:0]))
      else $error("accumulator write lost");

   // logical and
   and_result_a: assert property (exec && op == OP_AND && !to_file |=>
      acc_o == ($past(a_op) & $past(b_op)))
      else $error("and result wrong");

   // logical or
   or_result_a: assert property (exec && op == OP_OR && !to_file |=>
      acc_o == ($past(a_op) | $past(b_op)))
      else $error("or result wrong");

   // logical exclusive or
   xor_result_a: assert property (exec && op == OP_XOR && !to_file |=>
      acc_o == ($past(a_op) ^ $past(b_op)))
      else $error("xor result wrong");

   // subtract is file or immediate minus accumulator
   sub_result_a: assert property (exec && op == OP_SUB && !to_file |=>
      acc_o == $past(b_op) - $past(a_op))
      else $error("subtract result wrong");

   // increment wraps at the top
   inc_result_a: assert property (exec && op == OP_INC && !to_file |=>
      acc_o == $past(b_op) + 8'h01)
      else $error("increment result wrong");

   // decrement wraps at zero
   dec_result_a: assert property (exec && op == OP_DEC && !to_file |=>
      acc_o == $past(b_op) - 8'h01)
      else $error("decrement result wrong");

   // rotate left pulls the old carry into bit 0
   rlc_result_a: assert property (exec && op == OP_RLC && !to_file &&
      !low_voltage_reset_i |=>
      {flags_o[FLG_C], acc_o} == {$past(b_op), $past(flags_o[FLG_C])})
      else $error("rotate left result or carry wrong");

   // rotate right pulls the old carry into bit 7
   rrc_result_a: assert property (exec && op == OP_RRC && !to_file &&
      !low_voltage_reset_i |=>
      {acc_o, flags_o[FLG_C]} == {$past(flags_o[FLG_C]), $past(b_op)})
      else $error("rotate right result or carry wrong");

   // shifts leave the zero flag alone
   shift_keeps_z_a: assert property (exec && (op == OP_RLC || op == OP_RRC) &&
      !to_flags && !low_voltage_reset_i |=> $stable(flags_o[FLG_Z]))
      else $error("shift changed zero flag");

   // add sets nibble carry on a low nibble carry out
   add_nibble_a: assert property (exec && op == OP_ADD && !to_flags &&
      !low_voltage_reset_i |=> flags_o[FLG_NIB] ==
      (($past(a_op[3:0]) + $past(b_op[3:0])) > 5'h0F))
      else $error("add nibble carry wrong");

   // file destination leaves the accumulator alone
   file_keep_acc_a: assert property (exec && to_file |=> $stable(acc_o))
      else $error("file destination changed accumulator");

   // move to file carries the accumulator as result
   mov2f_result_a: assert property (exec && op == OP_ACC2F |=>
      q.res == $past(acc_o))
      else $error("move to file result wrong");

   // bit clear on the flag register
   bclr_flags_a: assert property (exec && op == OP_BCLR && to_flags &&
      imm[2:0] < 3'h3 && !low_voltage_reset_i |=>
      !flags_o[$past(imm[1:0])] && $stable(acc_o))
      else $error("bit clear on flags not written");

   // move to file on the flag register writes the bits directly
   mov2f_flags_a: assert property (exec && op == OP_ACC2F && to_flags &&
      !low_voltage_reset_i |=> flags_o[2:0] == $past(acc_o[2:0]))
      else $error("move to flags not written");

   // low-voltage reset clears all defined flags
   lowv_clear_a: assert property (low_voltage_reset_i |=>
      flags_o[4:0] == 5'h00)
      else $error("low-voltage reset left a flag set");

   // watchdog clear and sleep touch no data register
   event_keeps_acc_a: assert property (exec && (op == OP_WDTCLR || op == OP_SLEEP) |=>
      $stable(acc_o) && $stable(q.res))
      else $error("watchdog clear or sleep changed data");

endmodule : awsf_top

// *** common/awsf_pkg.sv ***
// constants and types shared by the alu with status flags
package awsf_pkg;
   // register byte offsets on the avalon slave
   localparam logic [4:0] ACC_OFS   = 5'h00;
   localparam logic [4:0] OPND_OFS  = 5'h04;
   localparam logic [4:0] CMD_OFS   = 5'h08;
   localparam logic [4:0] RES_OFS   = 5'h0C;
   localparam logic [4:0] FLAGS_OFS = 5'h10;
   // command word field positions
   localparam int CMD_OP_LSB     = 0;
   localparam int CMD_USE_IMM    = 4;
   localparam int CMD_DEST_FILE  = 5;
   localparam int CMD_DEST_FLAGS = 6;
   localparam int CMD_SRC_ACC    = 7;
   localparam int CMD_IMM_LSB    = 8;
   // flag bit positions
   localparam int FLG_C    = 0;
   localparam int FLG_NIB  = 1;
   localparam int FLG_Z    = 2;
   localparam int FLG_SLP  = 3;
   localparam int FLG_WDOG = 4;
   // flag update masks and reset values
   localparam logic [2:0]  UPD_ALL  = 3'h7;
   localparam logic [2:0]  UPD_Z    = 3'h4;
   localparam logic [2:0]  UPD_C    = 3'h1;
   localparam logic [7:0]  DATA_RST = 8'h00;
   localparam logic [15:0] CMD_RST  = 16'h0000;
   // alu operations
   typedef enum logic [3:0] {
      OP_MOV    = 4'h0,
      OP_ADD    = 4'h1,
      OP_SUB    = 4'h2,
      OP_AND    = 4'h3,
      OP_OR     = 4'h4,
      OP_XOR    = 4'h5,
      OP_COM    = 4'h6,
      OP_INC    = 4'h7,
      OP_DEC    = 4'h8,
      OP_RLC    = 4'h9,
      OP_RRC    = 4'hA,
      OP_BSET   = 4'hB,
      OP_BCLR   = 4'hC,
      OP_ACC2F  = 4'hD,
      OP_WDTCLR = 4'hE,
      OP_SLEEP  = 4'hF
   } awsf_op_t;
   // avalon request from the master
   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
   } awsf_av_req_t;
   // alu result with flags and update mask
   typedef struct packed {
      logic [7:0] res;
      logic [2:0] flg;
      logic [2:0] upd;
   } awsf_alu_out_t;
   // per-cycle control of the flag register
   typedef struct packed {
      logic       wr;
      logic [2:0] wdata;
      logic [2:0] upd;
      logic [2:0] alu;
      logic       wdt_to;
      logic       wdt_clr;
      logic       sleep;
      logic       lv_rst;
   } awsf_flag_ctl_t;
endpackage : awsf_pkg

// *** design/awsf_alu_core.sv ***
// combinational 8-bit alu with carry, nibble carry and zero
`timescale 1ns/10ps
module awsf_alu_core (
   input  wire awsf_pkg::awsf_op_t      op_i,
   input  wire logic [7:0]              a_i,
   input  wire logic [7:0]              b_i,
   input  wire logic                    cin_i,
   input  wire logic [2:0]              bit_i,
   output awsf_pkg::awsf_alu_out_t      out_o
);
   import awsf_pkg::*;
   logic [8:0] sum;
   logic [4:0] nib;

   // operation select; a is the accumulator side
   always_comb begin
      out_o = '0;
      sum   = {1'b0, a_i} + {1'b0, b_i};
      nib   = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
      unique case (op_i)
         OP_MOV: begin
            out_o.res = b_i;
            out_o.upd = UPD_Z;
         end
         OP_ADD: begin
            out_o.res       = sum[7:0];
            out_o.flg[FLG_C]  = sum[8];
            out_o.flg[FLG_NIB] = nib[4];
            out_o.upd       = UPD_ALL;
         end
         OP_SUB: begin // b minus a, carries are not-borrow
            sum = {1'b0, b_i} - {1'b0, a_i};
            nib = {1'b0, b_i[3:0]} - {1'b0, a_i[3:0]};
            out_o.res       = sum[7:0];
            out_o.flg[FLG_C]  = ~sum[8];
            out_o.flg[FLG_NIB] = ~nib[4];
            out_o.upd       = UPD_ALL;
         end
         OP_AND: begin
            out_o.res = a_i & b_i;
            out_o.upd = UPD_Z;
         end
         OP_OR: begin
            out_o.res = a_i | b_i;
            out_o.upd = UPD_Z;
         end
         OP_XOR: begin
            out_o.res = a_i ^ b_i;
            out_o.upd = UPD_Z;
         end
         OP_COM: begin
            out_o.res = ~b_i;
            out_o.upd = UPD_Z;
         end
         OP_INC: begin
            out_o.res = b_i + 8'h01;
            out_o.upd = UPD_Z;
         end
         OP_DEC: begin
            out_o.res = b_i - 8'h01;
            out_o.upd = UPD_Z;
         end
         OP_RLC: begin // shift left through carry
            out_o.res        = {b_i[6:0], cin_i};
            out_o.flg[FLG_C] = b_i[7];
            out_o.upd        = UPD_C;
         end
         OP_RRC: begin // shift right through carry
            out_o.res        = {cin_i, b_i[7:1]};
            out_o.flg[FLG_C] = b_i[0];
            out_o.upd        = UPD_C;
         end
         OP_BSET:   out_o.res = b_i | (8'h01 << bit_i);
         OP_BCLR:   out_o.res = b_i & ~(8'h01 << bit_i);
         OP_ACC2F:  out_o.res = a_i;
         OP_WDTCLR: out_o.res = b_i;
         OP_SLEEP:  out_o.res = b_i;
      endcase
      out_o.flg[FLG_Z] = (out_o.res == 8'h00);
   end
endmodule : awsf_alu_core

// *** design/awsf_flag_reg.sv ***
// flag register: arithmetic flags plus watchdog and sleep flags
`timescale 1ns/10ps
module awsf_flag_reg (
   input  wire logic                    clock_i,
   input  wire logic                    rst_b_i,
   input  wire awsf_pkg::awsf_flag_ctl_t ctl_i,
   output logic [7:0]                   flags_o
);
   import awsf_pkg::*;
   typedef struct packed {
      logic       wdog;
      logic       slp;
      logic [2:0] ar;
   } awsf_flg_st_t;
   awsf_flg_st_t q, d;

   // next flags; events set over clears, reset sources win
   always_comb begin
      d = q;
      if (ctl_i.wr) begin
         d.ar = ctl_i.wdata;
      end
      d.ar = (d.ar & ~ctl_i.upd) | (ctl_i.alu & ctl_i.upd);
      if (ctl_i.wdt_clr) begin
         d.wdog = 1'b0;
         d.slp  = 1'b0;
      end
      if (ctl_i.sleep) begin
         d.wdog = 1'b0;
         d.slp  = 1'b1;
      end
      if (ctl_i.wdt_to) begin
         d.wdog = 1'b1;
      end
      if (ctl_i.lv_rst) begin
         d = '0;
      end
   end

   // register, all defined bits clear at reset
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign flags_o = {3'h0, q.wdog, q.slp, q.ar};

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   wdog_set_a: assert property (ctl_i.wdt_to && !ctl_i.lv_rst |=>
      flags_o[FLG_WDOG])
      else $error("timeout did not set watchdog flag");
   sleep_set_a: assert property (ctl_i.sleep && !ctl_i.lv_rst |=>
      flags_o[FLG_SLP] && (flags_o[FLG_WDOG] == $past(ctl_i.wdt_to)))
      else $error("sleep did not set sleep flag");
   clr_both_a: assert property (ctl_i.wdt_clr && !ctl_i.wdt_to |=>
      flags_o[FLG_SLP +: 2] == 2'b00)
      else $error("watchdog clear left a flag set");
   hw_only_a: assert property (!ctl_i.wdt_to && !ctl_i.sleep && !ctl_i.wdt_clr &&
      !ctl_i.lv_rst |=> $stable(flags_o[FLG_WDOG:FLG_SLP]))
      else $error("sleep or watchdog flag moved without event");
   alu_wins_a: assert property (ctl_i.wr && !ctl_i.lv_rst |=>
      flags_o[2:0] == (($past(ctl_i.wdata) & ~$past(ctl_i.upd)) |
                       ($past(ctl_i.alu) & $past(ctl_i.upd))))
      else $error("flag write not merged with alu flags");
   rsvd_zero_a: assert property (flags_o[7:5] == 3'h0)
      else $error("reserved flag bits not zero");
endmodule : awsf_flag_reg

// *** bench/awsf_cpu_model.sv ***
// avalon master model standing in for the instruction decoder
`timescale 1ns/10ps
module awsf_cpu_model
   import awsf_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              av_waitrequest_i,
   input  wire logic [31:0]       av_readdata_i,
   output awsf_pkg::awsf_av_req_t av_o
);
   // bus idle from time zero
   initial begin
      av_o = '0;
   end
   // one transfer, held until waitrequest is seen low at an edge
   task automatic xfer(input logic rd, input logic [4:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
      @(posedge clock_i);
      av_o <= '{rd, ~rd, addr, wdata};
      do begin
         @(posedge clock_i);
      end while (av_waitrequest_i !== 1'b0);
      rdata = av_readdata_i;
      av_o <= '0;
   endtask : xfer
endmodule : awsf_cpu_model

// *** bench/awsf_top_tb.sv ***
// self-checking bench for the alu with status flags
`timescale 1ns/10ps
module awsf_top_tb;
   import awsf_pkg::*;
   typedef struct packed {
      logic [15:0] cmd;
      logic [7:0]  acc;
      logic [7:0]  opnd;
      logic [7:0]  res;
      logic [7:0]  flg;
   } awsf_vec_t;
   typedef struct packed {
      logic [1:0]  kind;
      logic [4:0]  addr;
      logic [15:0] data;
      logic [7:0]  flg;
   } awsf_step_t;
   logic         clk        = 1'b0;
   logic         rst_b      = 1'b0;
   logic         wdt        = 1'b0;
   logic         lv_rst     = 1'b0;
   awsf_av_req_t av;
   logic [31:0]  rdata;
   logic         waitreq;
   logic [7:0]   acc;
   logic [7:0]   flags;
   int           mismatches = 0;
   int           n_checks   = 0;
   int           cycles     = 0;

   // 20 mhz clock
   always #25 clk = ~clk;

   // design and bus master
   awsf_top awsf_top_inst (
      .clock_i(clk), .rst_b_i(rst_b), .av_i(av), .av_readdata_o(rdata),
      .av_waitrequest_o(waitreq), .watchdog_timeout_i(wdt), .low_voltage_reset_i(lv_rst),
      .acc_o(acc), .flags_o(flags));
   awsf_cpu_model awsf_cpu_model_inst (
      .clock_i(clk), .av_waitrequest_i(waitreq), .av_readdata_i(rdata), .av_o(av));

   // compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // register access through the master model
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      awsf_cpu_model_inst.xfer(1'b0, a, d, dummy);
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      awsf_cpu_model_inst.xfer(1'b1, a, 32'h0000_0000, d);
   endtask : rd

   // one step: register write or one-cycle event pulse, then flag check
   task automatic step(input awsf_step_t s);
      if (s.kind == 2'h0) begin
         wr(s.addr, {16'h0000, s.data});
      end else begin
         @(posedge clk);
         wdt    <= (s.kind == 2'h1);
         lv_rst <= (s.kind == 2'h2);
         @(posedge clk);
         wdt    <= 1'b0;
         lv_rst <= 1'b0;
      end
      @(negedge clk);
      chk("flags_o", {24'h0, s.flg}, {24'h0, flags});
   endtask : step

   // reset values, unused upper bits and an unmapped address
   task automatic t_reset;
      logic [31:0] d;
      chk("acc_o", 32'h0, {24'h0, acc});
      chk("flags_o", 32'h0, {24'h0, flags});
      rd(FLAGS_OFS, d);
      chk("flags read", 32'h0, d);
      rd(5'h14, d);
      chk("unmapped read", 32'h0, d);
      $display("test reset done");
   endtask : t_reset

   // arithmetic, logic and shift results with their flags
   task automatic t_alu;
      logic [31:0] d;
      awsf_vec_t v [16] = '{
         '{16'h7811, 8'h88, 8'h00, 8'h00, 8'h07}, // add, both carries, zero
         '{16'h0211, 8'h01, 8'h00, 8'h03, 8'h00}, // add, no carry
         '{16'h1012, 8'h01, 8'h00, 8'h0F, 8'h01}, // sub, nibble borrow
         '{16'h0512, 8'h05, 8'h00, 8'h00, 8'h07}, // sub, no borrow, zero
         '{16'h0012, 8'h01, 8'h00, 8'hFF, 8'h00}, // sub, both borrows
         '{16'h0F13, 8'hF0, 8'h00, 8'h00, 8'h04}, // and
         '{16'h0F14, 8'hF0, 8'h00, 8'hFF, 8'h00}, // or
         '{16'h5515, 8'h55, 8'h00, 8'h00, 8'h04}, // xor
         '{16'h0086, 8'h0F, 8'h00, 8'hF0, 8'h00}, // complement of accumulator
         '{16'h0007, 8'h00, 8'hFF, 8'h00, 8'h04}, // increment of file value
         '{16'h0089, 8'h80, 8'h00, 8'h00, 8'h05}, // rotate left, zero untouched
         '{16'h0001, 8'h03, 8'h04, 8'h07, 8'h00}, // add with file operand
         '{16'hA510, 8'h00, 8'h00, 8'hA5, 8'h00}, // move immediate
         '{16'h0008, 8'h00, 8'h01, 8'h00, 8'h04}, // decrement of file value
         '{16'h000A, 8'h00, 8'h03, 8'h01, 8'h05}, // rotate right, carry out
         '{16'h0089, 8'h40, 8'h00, 8'h81, 8'h04}}; // rotate left, carry in
      foreach (v[i]) begin
         wr(ACC_OFS, {24'h0, v[i].acc});
         wr(OPND_OFS, {24'h0, v[i].opnd});
         wr(CMD_OFS, {16'h0, v[i].cmd});
         @(negedge clk);
         chk("acc_o", {24'h0, v[i].res}, {24'h0, acc});
         chk("flags_o", {24'h0, v[i].flg}, {24'h0, flags});
         rd(RES_OFS, d);
         chk("result", {24'h0, v[i].res}, d);
      end
      rd(ACC_OFS, d);
      chk("acc read", 32'h0000_0081, d);
      rd(OPND_OFS, d);
      chk("operand read", 32'h0000_0000, d);
      rd(CMD_OFS, d);
      chk("command read", 32'h0000_0089, d);
      wr(RES_OFS, 32'h0000_00FF);
      rd(RES_OFS, d);
      chk("result after write", 32'h0000_0081, d);
      $display("test alu done");
   endtask : t_alu

   // software writes to the flag register
   task automatic t_flags;
      logic [31:0] d;
      awsf_step_t s [9] = '{
         '{2'h0, FLAGS_OFS, 16'h00FF, 8'h07}, // upper bits stay zero
         '{2'h0, CMD_OFS,   16'h014C, 8'h05}, // bit clear of bit 1
         '{2'h0, ACC_OFS,   16'h0002, 8'h05},
         '{2'h0, CMD_OFS,   16'h004D, 8'h02}, // move accumulator to flags
         '{2'h0, ACC_OFS,   16'h00FE, 8'h02},
         '{2'h0, CMD_OFS,   16'h0041, 8'h07}, // add into flags, alu flags win
         '{2'h0, ACC_OFS,   16'h0003, 8'h07},
         '{2'h0, CMD_OFS,   16'h0045, 8'h00}, // xor into flags, zero from alu
         '{2'h0, CMD_OFS,   16'h024B, 8'h04}}; // bit set of bit 2
      foreach (s[i]) begin
         step(s[i]);
      end
      rd(FLAGS_OFS, d);
      chk("flags read", 32'h0000_0004, d);
      $display("test flag writes done");
   endtask : t_flags

   // watchdog, sleep and low-voltage events
   task automatic t_hw;
      awsf_step_t s [9] = '{
         '{2'h0, FLAGS_OFS, 16'h0000, 8'h00},
         '{2'h1, 5'h00,     16'h0000, 8'h10}, // timeout sets bit 4
         '{2'h0, FLAGS_OFS, 16'h0000, 8'h10}, // software cannot clear it
         '{2'h0, CMD_OFS,   16'h000F, 8'h08}, // sleep
         '{2'h1, 5'h00,     16'h0000, 8'h18},
         '{2'h0, CMD_OFS,   16'h000E, 8'h00}, // watchdog clear
         '{2'h0, FLAGS_OFS, 16'h0005, 8'h05},
         '{2'h1, 5'h00,     16'h0000, 8'h15},
         '{2'h2, 5'h00,     16'h0000, 8'h00}}; // low-voltage reset
      foreach (s[i]) begin
         step(s[i]);
      end
      $display("test events done");
   endtask : t_hw

   // counts and verdict, then stop
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   // cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         wrap_up();
      end
   end

   // reset, then the scenarios in order
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_alu();
      t_flags();
      t_hw();
      wrap_up();
   end
endmodule : awsf_top_tb
